// file: hdl/crtcx_ext_regs.sv
// display timing extension register bank behind the index/data port
`timescale 1ns/100ps
`include "crtcx_regs.svh"
module crtcx_ext_regs
    import crtcx_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // index/data port: index in byte 0, data in byte 1
    input  wire logic        portWr,
    input  wire logic        portRd,
    input  wire logic [1:0]  portByteEn,
    input  wire logic [15:0] portWrData,
    output logic [15:0]      portRdData,
    // timing side
    input  wire logic        video_reset_input,
    input  wire logic        hsyncIn,
    input  wire logic        vsyncIn,
    input  wire logic [7:0]  hCount,
    input  wire logic        oddField,
    input  wire logic [16:0] host_addr,
    input  wire logic [1:0]  memMapSel,
    input  wire logic [1:0]  hZoom,
    input  wire logic        window0Active,
    input  wire logic [3:0]  fifoLevel,
    input  wire logic        reqIssued,
    output logic [4:0]       startAddrHigh,
    output logic [1:0]       lineOffsetHigh,
    output logic             interlaceEn,
    output logic             hTotalBit8,
    output logic             hBlankStartBit8,
    output logic             hRetraceStartBit8,
    output logic             hBlankEndBit6,
    output logic             hCounterReset,
    output logic             vCounterReset,
    output logic             hsyncOut,
    output logic             vsyncOut,
    output logic [1:0]       vTotalHigh,
    output logic             vDisplayEndBit10,
    output logic [1:0]       vBlankStartHigh,
    output logic [1:0]       vRetraceStartHigh,
    output logic             lineCompareBit10,
    output logic             pixelEn,
    output logic             compositeSyncEn,
    output logic             mode13_accel_disable,
    output logic             nativePixelPath,
    output logic             zoomClockedCounter,
    output logic             linearApertureOk,
    output logic [23:0]      apertureAddr,
    output logic             halfLineAdvance,
    output logic             fifoHighPri,
    output logic             refreshBlocked
);
    crtcx_byte_t regs_q [`CRTCX_NUM_REGS];
    logic [2:0]  index_q;
    logic [2:0]  wrIndex;
    logic        pixelEnRaw;
    logic        highPriRaw;

    function automatic crtcx_byte_t wrMask(input logic [2:0] idx);
        unique case (idx)
            `CRTCX_IDX_MISC_MODE:     wrMask = `CRTCX_MASK_MISC_MODE;
            `CRTCX_IDX_FIFO_PRIORITY: wrMask = `CRTCX_MASK_FIFO_PRIORITY;
            `CRTCX_IDX_REQUEST_BLOCK: wrMask = `CRTCX_MASK_REQUEST_BLOCK;
            default:                  wrMask = `CRTCX_MASK_FULL;
        endcase
    endfunction

    // a word write uses its own new index for the data byte
    assign wrIndex = portByteEn[0] ? portWrData[2:0] : index_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            index_q <= 3'h0;
        end else if (ce && portWr && portByteEn[0]) begin
            index_q <= portWrData[2:0];
        end
    end

    // reserved bits are stored as zero so reads give zeros whatever software wrote
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `CRTCX_NUM_REGS; i++) begin
                regs_q[i] <= `CRTCX_REG_RESET;
            end
        end else if (ce && portWr && portByteEn[1]) begin
            regs_q[wrIndex] <= portWrData[15:8] & wrMask(wrIndex);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            portRdData <= 16'h0000;
        end else if (ce && portRd) begin
            portRdData <= {regs_q[index_q], 5'h00, index_q};
        end
    end

    // address, width and timing extension bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            startAddrHigh     <= 5'h00;
            lineOffsetHigh    <= 2'h0;
            interlaceEn       <= 1'b0;
            hTotalBit8        <= 1'b0;
            hBlankStartBit8   <= 1'b0;
            hRetraceStartBit8 <= 1'b0;
            hBlankEndBit6     <= 1'b0;
            vTotalHigh        <= 2'h0;
            vDisplayEndBit10  <= 1'b0;
            vBlankStartHigh   <= 2'h0;
            vRetraceStartHigh <= 2'h0;
            lineCompareBit10  <= 1'b0;
        end else if (ce) begin
            startAddrHigh     <= {regs_q[0][6], regs_q[0][3:0]};
            lineOffsetHigh    <= regs_q[0][5:4];
            interlaceEn       <= regs_q[0][7];
            hTotalBit8        <= regs_q[1][0];
            hBlankStartBit8   <= regs_q[1][1];
            hRetraceStartBit8 <= regs_q[1][2];
            // the blanking end bit only matters to the native timing path
            hBlankEndBit6     <= regs_q[1][6] & regs_q[3][`CRTCX_MISC_NATIVE];
            vTotalHigh        <= regs_q[2][1:0];
            vDisplayEndBit10  <= regs_q[2][2];
            vBlankStartHigh   <= regs_q[2][4:3];
            vRetraceStartHigh <= regs_q[2][6:5];
            lineCompareBit10  <= regs_q[2][7];
        end
    end

    // counter resets and sync gating
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hCounterReset <= 1'b0;
            vCounterReset <= 1'b0;
            hsyncOut      <= 1'b0;
            vsyncOut      <= 1'b0;
        end else if (ce) begin
            hCounterReset <= video_reset_input & regs_q[1][`CRTCX_HCTR_HRESET_EN];
            vCounterReset <= video_reset_input & regs_q[1][`CRTCX_HCTR_VRESET_EN];
            // inactive is taken as low here; polarity is applied downstream
            hsyncOut      <= hsyncIn & ~regs_q[1][`CRTCX_HCTR_HSYNC_OFF];
            vsyncOut      <= vsyncIn & ~regs_q[1][`CRTCX_HCTR_VSYNC_OFF];
        end
    end

    // mode selection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            compositeSyncEn      <= 1'b0;
            mode13_accel_disable <= 1'b0;
            nativePixelPath      <= 1'b0;
            zoomClockedCounter   <= 1'b0;
            linearApertureOk     <= 1'b0;
            pixelEn              <= 1'b0;
        end else if (ce) begin
            compositeSyncEn      <= regs_q[3][`CRTCX_MISC_CSYNC_EN];
            mode13_accel_disable <= regs_q[3][`CRTCX_MISC_MODE13_ACCEL_DIS];
            nativePixelPath      <= regs_q[3][`CRTCX_MISC_NATIVE];
            zoomClockedCounter   <= regs_q[3][`CRTCX_MISC_NATIVE];
            linearApertureOk     <= regs_q[3][`CRTCX_MISC_NATIVE];
            pixelEn              <= pixelEnRaw;
        end
    end

    // paged VGA aperture; undefined map selects give address zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            apertureAddr <= 24'h000000;
        end else if (ce) begin
            unique case (memMapSel)
                `CRTCX_MAP_128K: apertureAddr <= {regs_q[4][7:1], host_addr};
                `CRTCX_MAP_64K:  apertureAddr <= {regs_q[4], host_addr[15:0]};
                default:         apertureAddr <= 24'h000000;
            endcase
        end
    end

    // half-line, priority and refresh blocking
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            halfLineAdvance <= 1'b0;
            fifoHighPri     <= 1'b0;
            refreshBlocked  <= 1'b0;
        end else if (ce) begin
            halfLineAdvance <= regs_q[0][7] & oddField & (hCount == regs_q[5]);
            fifoHighPri     <= highPriRaw;
            refreshBlocked  <= regs_q[7][0] & (hZoom == `CRTCX_ZOOM_X1)
                               & window0Active;
        end
    end

    crtcx_clk_div u_clk_div (
        .clk        (clk),
        .rst        (rst),
        .ce         (ce),
        .nativeMode (regs_q[3][`CRTCX_MISC_NATIVE]),
        .scale      (regs_q[3][2:0]),
        .pixelEn    (pixelEnRaw)
    );

    crtcx_fifo_pri u_fifo_pri (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .fifoLevel (fifoLevel),
        .reqIssued (reqIssued),
        .levelCode (regs_q[6][2:0]),
        .maxCode   (regs_q[6][6:4]),
        .highPri   (highPriRaw)
    );
endmodule

// file: hdl/crtcx_regs.svh
// constants for the display timing extension register bank
//
// Contract
// - data byte reaches the extension register chosen by the 3-bit index, 00h-07h
// - start address bits 19:16 from ext0 bits 3:0, bit 20 from ext0 bit 6
// - line width bits 9:8 come from ext0 bits 5:4
// - ext0 bit 7 selects interlaced scanning, zero non-interlaced
// - ext2 fields widen vertical timing to 12 bits, plus display-end and compare bit 10
// - ext3 bit 5 disables mode 13 direct frame buffer acceleration
// - ext3 bit 7 low: attribute controller path, count-by clocking, no linear aperture
// - ext3 bit 7 high: engine pixels direct to DAC, counter clocked by zoom
// - ext4 page bits extend the VGA aperture to reach 16 megabytes
// - map select 00 joins page 7:1 with address 16:0; 01 page 7:0 with 15:0
// - interlaced only: ext5 is the half-line count that advances vertical counter
// - FIFO request goes high priority at level code plus one 8-qword requests
// - once high, at least max code plus one high priority requests are made
// - ext7 bit 0 with zoom 00 blocks refresh requests while window 0 shows
`ifndef CRTCX_REGS_SVH
`define CRTCX_REGS_SVH

`define CRTCX_IDX_START_OFFSET_INTERLACE 3'h0
`define CRTCX_IDX_HORIZONTAL_COUNTER     3'h1
`define CRTCX_IDX_VERTICAL_COUNTER       3'h2
`define CRTCX_IDX_MISC_MODE              3'h3
`define CRTCX_IDX_FRAME_PAGE             3'h4
`define CRTCX_IDX_HALF_LINE              3'h5
`define CRTCX_IDX_FIFO_PRIORITY          3'h6
`define CRTCX_IDX_REQUEST_BLOCK          3'h7
`define CRTCX_NUM_REGS                   8
`define CRTCX_REG_RESET                  8'h00

// writable bit masks, reserved bits forced to zero
`define CRTCX_MASK_MISC_MODE             8'he7
`define CRTCX_MASK_FIFO_PRIORITY         8'h77
`define CRTCX_MASK_REQUEST_BLOCK         8'h01
`define CRTCX_MASK_FULL                  8'hff

// ext3 fields
`define CRTCX_MISC_SCALE_LSB             0
`define CRTCX_MISC_MODE13_ACCEL_DIS      5
`define CRTCX_MISC_CSYNC_EN              6
`define CRTCX_MISC_NATIVE                7
// ext1 fields
`define CRTCX_HCTR_HRESET_EN             3
`define CRTCX_HCTR_HSYNC_OFF             4
`define CRTCX_HCTR_VSYNC_OFF             5
`define CRTCX_HCTR_VRESET_EN             7
// ext6 fields
`define CRTCX_PRI_LEVEL_LSB              0
`define CRTCX_PRI_MAX_LSB                4

`define CRTCX_MAP_128K                   2'h0
`define CRTCX_MAP_64K                    2'h1
`define CRTCX_ZOOM_X1                    2'h0

`endif

// file: hdl/crtcx_pkg.sv
// types shared by the extension register bank modules
package crtcx_pkg;
    typedef enum logic [1:0] {
        CRTCX_PRI_LOW  = 2'b01,
        CRTCX_PRI_HIGH = 2'b10
    } crtcx_pri_state_t;

    typedef logic [7:0] crtcx_byte_t;
endpackage

// file: hdl/crtcx_clk_div.sv
// video clock divider producing a pixel enable pulse
`timescale 1ns/100ps
`include "crtcx_regs.svh"
module crtcx_clk_div
    import crtcx_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       nativeMode,
    input  wire logic [2:0] scale,
    output logic            pixelEn
);
    logic [2:0] cnt_q;
    logic [2:0] last;

    // reserved codes fall back to divide by 1 so the pipe never stalls
    function automatic logic [2:0] divLast(input logic [2:0] code);
        unique case (code)
            3'h1:    divLast = 3'h1;
            3'h2:    divLast = 3'h2;
            3'h3:    divLast = 3'h3;
            3'h5:    divLast = 3'h5;
            3'h7:    divLast = 3'h7;
            default: divLast = 3'h0;
        endcase
    endfunction

    assign last = nativeMode ? divLast(scale) : 3'h0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q   <= 3'h0;
            pixelEn <= 1'b0;
        end else if (ce) begin
            if (cnt_q >= last) begin
                cnt_q   <= 3'h0;
                pixelEn <= 1'b1;
            end else begin
                cnt_q   <= cnt_q + 3'h1;
                pixelEn <= 1'b0;
            end
        end
    end
endmodule

// file: hdl/crtcx_fifo_pri.sv
// display fifo request priority controller
`timescale 1ns/100ps
`include "crtcx_regs.svh"
module crtcx_fifo_pri
    import crtcx_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic [3:0] fifoLevel,
    input  wire logic       reqIssued,
    input  wire logic [2:0] levelCode,
    input  wire logic [2:0] maxCode,
    output logic            highPri
);
    crtcx_pri_state_t state_q;
    logic [3:0]       issued_q;
    logic             atLevel;
    logic             doneMin;

    assign atLevel = fifoLevel <= ({1'b0, levelCode} + 4'h1);
    assign doneMin = issued_q >= ({1'b0, maxCode} + 4'h1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q  <= CRTCX_PRI_LOW;
            issued_q <= 4'h0;
            highPri  <= 1'b0;
        end else if (ce) begin
            unique case (state_q)
                CRTCX_PRI_LOW: begin
                    issued_q <= 4'h0;
                    if (atLevel) begin
                        state_q <= CRTCX_PRI_HIGH;
                        highPri <= 1'b1;
                    end
                end
                CRTCX_PRI_HIGH: begin
                    // stay until the minimum burst is out and the fifo has recovered
                    if (doneMin && !atLevel) begin
                        state_q <= CRTCX_PRI_LOW;
                        highPri <= 1'b0;
                    end else if (reqIssued && !doneMin) begin
                        issued_q <= issued_q + 4'h1;
                    end
                end
                default: begin
                    state_q <= CRTCX_PRI_LOW;
                    highPri <= 1'b0;
                end
            endcase
        end
    end
endmodule

// file: dv/crtcx_ext_regs_chk.sv
// concurrent checks on the ports of the extension register bank
`timescale 1ns/100ps
module crtcx_ext_regs_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        portRd,
    input wire logic [15:0] portRdData,
    input wire logic        video_reset_input,
    input wire logic        hsyncIn,
    input wire logic        vsyncIn,
    input wire logic        oddField,
    input wire logic [16:0] host_addr,
    input wire logic [1:0]  memMapSel,
    input wire logic [1:0]  hZoom,
    input wire logic        window0Active,
    input wire logic        hCounterReset,
    input wire logic        vCounterReset,
    input wire logic        hsyncOut,
    input wire logic        vsyncOut,
    input wire logic        pixelEn,
    input wire logic [23:0] apertureAddr,
    input wire logic        halfLineAdvance,
    input wire logic        refreshBlocked
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // derived outputs lag their cause by one enabled cycle
    AST_HCTR_RESET: assert property ($past(ce) && hCounterReset |-> $past(video_reset_input))
        else $error("horizontal counter reset without video reset");
    AST_VCTR_RESET: assert property ($past(ce) && vCounterReset |-> $past(video_reset_input))
        else $error("vertical counter reset without video reset");
    AST_HSYNC_GATE: assert property ($past(ce) && hsyncOut |-> $past(hsyncIn))
        else $error("horizontal sync active without input sync");
    AST_VSYNC_GATE: assert property ($past(ce) && vsyncOut |-> $past(vsyncIn))
        else $error("vertical sync active without input sync");
    AST_REFRESH_BLOCK: assert property ($past(ce) && refreshBlocked |->
        $past(hZoom) == 2'h0 && $past(window0Active))
        else $error("refresh blocked outside window 0 at zoom 00");
    AST_RD_HOLD: assert property (!($past(portRd) && $past(ce)) |-> $stable(portRdData))
        else $error("read data changed without a read");
    AST_RD_INDEX_ZERO: assert property (portRdData[7:3] == 5'h00)
        else $error("read data index byte has nonzero upper bits");
    AST_PIXEL_GAP: assert property (ce && !pixelEn |-> ##[1:7] (pixelEn || !ce))
        else $error("pixel enable gap longer than divide by 8");
    AST_HALF_LINE: assert property ($past(ce) && halfLineAdvance |-> $past(oddField))
        else $error("half line advance outside odd field");
    AST_MAP128K: assert property (!$past(rst) && $past(ce) && $past(memMapSel) == 2'h0 |->
        apertureAddr[16:0] == $past(host_addr))
        else $error("128K window lost host address bits");
endmodule
bind crtcx_ext_regs crtcx_ext_regs_chk chk_u (.*);

// file: dv/crtcx_ext_regs_bench.sv
// directed testbench for the extension register bank
`timescale 1ns/100ps
module crtcx_ext_regs_bench;
    logic        clk, rst, ce, portWr, portRd, video_reset_input, hsyncIn, vsyncIn, oddField;
    logic        window0Active, reqIssued, interlaceEn, hTotalBit8, hBlankStartBit8;
    logic        hRetraceStartBit8, hBlankEndBit6, hCounterReset, vCounterReset, hsyncOut;
    logic        vsyncOut, vDisplayEndBit10, lineCompareBit10, pixelEn, compositeSyncEn;
    logic        mode13_accel_disable, nativePixelPath, zoomClockedCounter, linearApertureOk;
    logic        halfLineAdvance, fifoHighPri, refreshBlocked;
    logic [1:0]  portByteEn, memMapSel, hZoom, lineOffsetHigh, vTotalHigh;
    logic [1:0]  vBlankStartHigh, vRetraceStartHigh;
    logic [3:0]  fifoLevel;
    logic [4:0]  startAddrHigh;
    logic [7:0]  hCount;
    logic [15:0] portWrData, portRdData, v;
    logic [16:0] host_addr;
    logic [23:0] apertureAddr;
    int          n_mismatch, total_checks, i, n;
    logic [7:0]  maskTab [8] = '{8'hff, 8'hff, 8'hff, 8'he7, 8'hff, 8'hff, 8'h77, 8'h01};
    int          divTab [8] = '{1, 2, 3, 4, 1, 6, 1, 8};
    logic [7:0]  syncTab [3] = '{8'h00, 8'h88, 8'h30};
    logic [23:0] apTab [4] = '{24'haa2345, 24'hab2345, 24'h000000, 24'h000000};

    crtcx_ext_regs dut_u (.*);

    always #5 clk = ~clk;

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic port(input logic [1:0] be, input logic [15:0] d);
        @(posedge clk);
        portWr <= 1'b1;
        portByteEn <= be;
        portWrData <= d;
        @(posedge clk);
        portWr <= 1'b0;
    endtask
    task automatic wr(input logic [2:0] idx, input logic [7:0] val);
        port(2'h3, {val, 5'h00, idx});
    endtask
    task automatic rdCur(output logic [15:0] val);
        @(posedge clk);
        portRd <= 1'b1;
        @(posedge clk);
        portRd <= 1'b0;
        #1 val = portRdData;
    endtask
    task automatic rd(input logic [2:0] idx, output logic [15:0] val);
        port(2'h1, {8'h00, 5'h00, idx});
        rdCur(val);
    endtask
    // fixed wait: register stage plus the derived output stage
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic period(output int cnt);
        int k;
        cnt = 0;
        for (k = 0; k < 20 && pixelEn !== 1'b1; k++) @(posedge clk) #1;
        for (k = 0; k < 20 && (cnt == 0 || pixelEn !== 1'b1); k++) begin
            @(posedge clk);
            #1 cnt++;
        end
        if (pixelEn !== 1'b1) begin
            n_mismatch++;
            finish_test();
        end
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        {portWr, portRd, video_reset_input, hsyncIn, vsyncIn, oddField} = '0;
        {window0Active, reqIssued, portByteEn, memMapSel, hZoom, hCount} = '0;
        {portWrData, host_addr} = '0;
        // a full fifo keeps the requester at low priority until the test wants otherwise
        fifoLevel = 4'hf;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 8; i++) begin
            rd(i[2:0], v);
            check("reset value", v, {8'h00, 5'h00, i[2:0]});
        end
        port(2'h1, 16'h0003);
        port(2'h2, 16'h8000);
        rdCur(v);
        check("split write", v, 16'h8003);
        done("reset");
        // software keeps reserved bits at zero, so every write is masked on this side
        for (i = 0; i < 8; i++) wr(i[2:0], (8'h96 ^ (i[7:0] * 8'h1d)) & maskTab[i]);
        for (i = 0; i < 8; i++) begin
            rd(i[2:0], v);
            check("pattern", v,
                {(8'h96 ^ (i[7:0] * 8'h1d)) & maskTab[i], 5'h00, i[2:0]});
            wr(i[2:0], maskTab[i]);
            rd(i[2:0], v);
            check("ones", v, {maskTab[i], 5'h00, i[2:0]});
        end
        done("access");
        wr(0, 8'hd7);
        wr(4, 8'h00); // page cleared before leaving native mode
        wr(3, 8'h00);
        wr(1, 8'h47);
        wr(2, 8'hb5);
        settle();
        check("ext0 fields", {startAddrHigh, lineOffsetHigh, interlaceEn}, 8'hbb);
        check("ext1 ext2", {hTotalBit8, hBlankStartBit8, hRetraceStartBit8, hBlankEndBit6,
            vTotalHigh, vDisplayEndBit10, vBlankStartHigh, vRetraceStartHigh,
            lineCompareBit10}, 12'he73);
        done("timing");
        @(posedge clk);
        {video_reset_input, hsyncIn, vsyncIn} <= 3'h7;
        for (i = 0; i < 3; i++) begin
            wr(1, syncTab[i]);
            settle();
            check("sync gating", {hCounterReset, vCounterReset, hsyncOut, vsyncOut},
                {syncTab[i][3], syncTab[i][7], ~syncTab[i][4], ~syncTab[i][5]});
        end
        wr(1, 8'h88);
        @(posedge clk);
        video_reset_input <= 1'b0;
        settle();
        check("reset idle", {hCounterReset, vCounterReset}, 2'h0);
        done("sync");
        for (i = 0; i < 8; i++) begin
            wr(3, 8'h80 | i[7:0]);
            settle();
            period(n);
            check("divide", n, divTab[i]);
        end
        wr(1, 8'h40);
        settle();
        check("native mode", {nativePixelPath, zoomClockedCounter, linearApertureOk,
            hBlankEndBit6}, 4'hf);
        wr(3, 8'h63);
        settle();
        period(n);
        check("vga divide", n, 1);
        check("misc flags", {compositeSyncEn, mode13_accel_disable, nativePixelPath,
            zoomClockedCounter, linearApertureOk, hBlankEndBit6}, 6'h30);
        done("misc");
        wr(3, 8'h80); // a nonzero page is only legal in native mode
        wr(4, 8'hab);
        @(posedge clk);
        host_addr <= 17'h02345;
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            memMapSel <= i[1:0];
            settle();
            check("aperture", apertureAddr, apTab[i]);
        end
        wr(5, 8'h3c);
        for (i = 0; i < 4; i++) begin
            wr(0, (i == 3) ? 8'h00 : 8'h80);
            @(posedge clk);
            hCount <= (i == 1) ? 8'h3d : 8'h3c;
            oddField <= (i != 2);
            settle();
            check("half line", halfLineAdvance, i == 0);
        end
        done("aperture");
        wr(6, 8'h12);
        settle();
        check("fifo low", fifoHighPri, 1'b0);
        for (i = 4; i >= 3; i--) begin
            @(posedge clk);
            fifoLevel <= i[3:0];
            settle();
            check("fifo threshold", fifoHighPri, i == 3);
        end
        @(posedge clk);
        fifoLevel <= 4'hf;
        for (i = 0; i < 3; i++) begin
            settle();
            check("fifo min high", fifoHighPri, i < 2);
            @(posedge clk);
            reqIssued <= 1'b1;
            @(posedge clk);
            reqIssued <= 1'b0;
        end
        done("fifo");
        for (i = 0; i < 4; i++) begin
            wr(7, (i == 3) ? 8'h00 : 8'h01);
            @(posedge clk);
            hZoom <= (i == 1) ? 2'h1 : 2'h0;
            window0Active <= (i != 2);
            settle();
            check("refresh block", refreshBlocked, i == 0);
        end
        @(posedge clk);
        ce <= 1'b0;
        wr(4, 8'h00);
        @(posedge clk);
        ce <= 1'b1;
        rd(4, v);
        check("frozen write", v, 16'hab04);
        done("block");
        finish_test();
    end
endmodule
